//--- sim/iotfrc_timer_sva.sv
// Port assertions for the free-running timer
`timescale 1ns/1ns
module iotfrc_sva
  import iotfrc_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [15:0] time_base,
  input wire logic [1:0]  compare_out,
  input wire logic [1:0]  capture_irq,
  input wire logic [1:0]  capture_dma_req,
  input wire logic        timer_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================================
  // Age since last write beat; a loaded count may jump, so steps are judged later
  logic [2:0] wr_age_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || (s_axi_wvalid && s_axi_wready)) wr_age_q <= 3'h0;
    else if (wr_age_q != 3'h7) wr_age_q <= wr_age_q + 3'h1;
  end

  // ==========================================================================
  // Counter and reset
  chk_count_step: assert property (
    wr_age_q > 3'h4 && $changed(time_base)
      |-> time_base == $past(time_base) + 16'h1 || time_base == 16'h0)
    else $error("count moved by other than one");
  chk_reset_zero: assert property (disable iff (1'b0)
    !aresetn |=> time_base == 16'h0 && !timer_irq && capture_irq == 2'b00)
    else $error("outputs not cleared by reset");
  chk_ready_start: assert property (
    $rose(aresetn) |-> ##2 s_axi_awready && s_axi_wready && s_axi_arready)
    else $error("bus not ready after reset");
  chk_dma_mirror: assert property (capture_dma_req == capture_irq)
    else $error("dma request differs from capture request");

  // ==========================================================================
  // Register bus timing
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not two cycles later");
  chk_read_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not released");
  chk_write_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not released");
  chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");

  cover property (s_axi_bvalid && s_axi_bresp == IOTFRC_RESP_SLVERR);
  cover property ($fell(compare_out[1]));
  cover property ($rose(capture_irq[0]));
endmodule : iotfrc_sva

//--- sim/tb.sv
// Self-checking bench for the free-running timer
`timescale 1ns/1ns
module tb;
  import iotfrc_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rmw_read = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [1:0]  capture_pin = 2'b00;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, compare_out, capture_irq, capture_dma_req;
  logic [31:0] s_axi_rdata, rd;
  logic [15:0] time_base;
  logic        timer_irq;
  logic [1:0]  rsp;
  logic [31:0] lfsr = 32'h1fde;
  int          errors = 0, cmp_count = 0, cyc = 0, t_wr = 0;

  // Clock and a free cycle count used to time the rate checks
  always #4 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  iotfrc_timer i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rmw_read, .capture_pin, .time_base,
    .compare_out, .capture_irq, .capture_dma_req, .timer_irq);

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  // ==========================================================================
  // Bus tasks: both channels offered together, each released once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    t_wr = cyc;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [3:0] a, input logic rmw = 1'b0);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    rmw_read <= rmw;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    rmw_read <= 1'b0;
  endtask : rdr

  // ==========================================================================
  // Compare tasks: exact value, and count within a tolerance
  task automatic check_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : check_val

  task automatic check_near(input string nm, input int exp, input int tol,
                            input logic [15:0] got);
    cmp_count++;
    if (^got === 1'bx || int'(got) > exp + tol || int'(got) < exp - tol) begin
      errors++;
      $display("BAD %s expected %0d seen %h", nm, exp, got);
    end
  endtask : check_near

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  // Run needs a few thousand cycles; the margin covers a stalled bus
  initial begin
    repeat (40000) @(posedge aclk);
    errors++;
    tally_and_finish();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    int n;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rdr(IOTFRC_OFF_CTRL);
    check_val("ctrl reset", {24'h0, IOTFRC_CTRL_RESET}, rd);
    rdr(IOTFRC_OFF_COUNT);
    check_near("count start", 10, 10, rd[15:0]);
    // Stopped counter holds a random load; narrow write is refused
    wr(IOTFRC_OFF_CTRL, 32'h20);
    lfsr = lfsr_next(lfsr);
    wr(IOTFRC_OFF_COUNT, {16'h0, lfsr[15:0]});
    repeat (20) @(posedge aclk);
    wr(IOTFRC_OFF_COUNT, 32'h5a5a, 4'h1);
    check_val("narrow resp", IOTFRC_RESP_SLVERR, rsp);
    rdr(IOTFRC_OFF_COUNT);
    check_val("count held", {16'h0, lfsr[15:0]}, rd);
    // Every rate code: ticks over a measured run interval
    for (int c = 0; c < 8; c++) begin
      wr(IOTFRC_OFF_COUNT, 32'h0);
      wr(IOTFRC_OFF_CTRL, 32'(c));
      n = t_wr;
      repeat (200) @(posedge aclk);
      wr(IOTFRC_OFF_CTRL, 32'h20 | 32'(c));
      rdr(IOTFRC_OFF_COUNT);
      check_near("rate count", (t_wr - n) >> c, int'(c != 0), rd[15:0]);
    end
    // Overflow sets the flag; enable gates it; write one keeps, zero clears
    wr(IOTFRC_OFF_COUNT, 32'hfffe);
    wr(IOTFRC_OFF_CTRL, 32'h40);
    rdr(IOTFRC_OFF_CTRL);
    check_val("overflow flag", 32'hc0, rd);
    check_val("irq on", 1'b1, timer_irq);
    rdr(IOTFRC_OFF_COUNT);
    check_near("wrap", 4, 4, rd[15:0]);
    wr(IOTFRC_OFF_CTRL, 32'h80);
    @(posedge aclk);
    check_val("irq masked", 1'b0, timer_irq);
    rdr(IOTFRC_OFF_CTRL);
    check_val("flag write one", 32'h80, rd);
    wr(IOTFRC_OFF_CTRL, 32'h00);
    rdr(IOTFRC_OFF_CTRL);
    check_val("flag cleared", 32'h00, rd);
    rdr(IOTFRC_OFF_CTRL, 1'b1);
    check_val("rmw flag", 32'h80, rd);
    // Clear mode: compare 0 match wraps the count and flags it
    wr(IOTFRC_OFF_CTRL, 32'h20);
    wr(IOTFRC_OFF_COUNT, 32'h0);
    wr(IOTFRC_OFF_CMP0, 32'h20);
    wr(IOTFRC_OFF_CTRL, 32'h10);
    for (int k = 0; k < 4; k++) begin
      lfsr = lfsr_next(lfsr);
      repeat (lfsr[5:0]) @(posedge aclk);
      rdr(IOTFRC_OFF_COUNT);
      check_near("mode clear", 16, 16, rd[15:0]);
    end
    rdr(IOTFRC_OFF_CTRL);
    check_val("match flag", 1'b1, rd[7]);
    // Soft clear of a running count; the bit reads back zero
    wr(IOTFRC_OFF_CTRL, 32'h20);
    wr(IOTFRC_OFF_COUNT, 32'h1234);
    wr(IOTFRC_OFF_CTRL, 32'h00);
    wr(IOTFRC_OFF_CTRL, 32'h08);
    rdr(IOTFRC_OFF_COUNT);
    check_near("soft clear", 8, 8, rd[15:0]);
    rdr(IOTFRC_OFF_CTRL);
    check_val("soft bit", 32'h00, rd);
    // Compare 1: start level, toggle on match, its own request
    wr(IOTFRC_OFF_CTRL, 32'h20);
    wr(IOTFRC_OFF_COUNT, 32'h0);
    wr(IOTFRC_OFF_CMP1, 32'h0005_0010);
    @(posedge aclk);
    check_val("start low", 1'b0, compare_out[1]);
    wr(IOTFRC_OFF_CMP1, 32'h0007_0010);
    @(posedge aclk);
    check_val("start level", 1'b1, compare_out[1]);
    wr(IOTFRC_OFF_CTRL, 32'h00);
    repeat (30) @(posedge aclk);
    check_val("toggle", 1'b0, compare_out[1]);
    check_val("cmp irq", 1'b1, timer_irq);
    wr(IOTFRC_OFF_CMP1, 32'h0000_0010);
    @(posedge aclk);
    check_val("cmp irq off", 1'b0, timer_irq);
    // Capture on a stopped, randomly loaded count: ch0 on rise, ch1 on fall only
    wr(IOTFRC_OFF_CTRL, 32'h0920, 4'h3);
    lfsr = lfsr_next(lfsr);
    wr(IOTFRC_OFF_COUNT, {16'h0, lfsr[15:0]});
    capture_pin <= 2'b01;
    repeat (6) @(posedge aclk);
    check_val("rise capture", 2'b01, capture_irq);
    capture_pin <= 2'b11;
    repeat (6) @(posedge aclk);
    check_val("rise ignored", 2'b01, capture_irq);
    capture_pin <= 2'b01;
    repeat (6) @(posedge aclk);
    check_val("fall capture", 2'b11, capture_irq);
    check_val("dma req", 2'b11, capture_dma_req);
    rdr(IOTFRC_OFF_COUNT);
    check_val("capture value 0", {16'h0, lfsr[15:0]}, {16'h0, rd[31:16]});
    rdr(IOTFRC_OFF_CTRL);
    check_val("capture value 1", {16'h0, lfsr[15:0]}, {16'h0, rd[29:14]});
    wr(IOTFRC_OFF_CTRL, 32'h0900, 4'h3);
    @(posedge aclk);
    check_val("capture clear", 2'b00, capture_irq);
    // Reset in mid-run
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    check_val("reset count", 16'h0, time_base);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rdr(IOTFRC_OFF_CTRL);
    check_val("ctrl after reset", 32'h0, rd);
    tally_and_finish();
  end
endmodule : tb

bind iotfrc_timer iotfrc_sva i_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .time_base, .compare_out, .capture_irq,
  .capture_dma_req, .timer_irq);

//--- verilog/iotfrc_pkg.sv
// Package for the free-running timer: register map, field layout, reset values, carriers
package iotfrc_pkg;

  // ==========================================================================
  // Register map (byte addresses, one aligned word each)
  localparam logic [3:0] IOTFRC_OFF_COUNT   = 4'h0;
  localparam logic [3:0] IOTFRC_OFF_CTRL    = 4'h4;
  localparam logic [3:0] IOTFRC_OFF_CMP0    = 4'h8;
  localparam logic [3:0] IOTFRC_OFF_CMP1    = 4'hc;
  localparam int         IOTFRC_ADDR_W      = 4;

  // ==========================================================================
  // Low control/status fields
  localparam int IOTFRC_B_IRQ_FLAG   = 7;
  localparam int IOTFRC_B_IRQ_EN     = 6;
  localparam int IOTFRC_B_STOP       = 5;
  localparam int IOTFRC_B_CLR_MODE   = 4;
  localparam int IOTFRC_B_SOFT_ZERO  = 3;
  localparam int IOTFRC_B_RATE_HI    = 2;
  localparam int IOTFRC_B_RMW        = 8;   // Read strobe: flag reads as one
  localparam logic [7:0] IOTFRC_CTRL_RESET  = 8'h00;
  localparam logic [15:0] IOTFRC_COUNT_RESET = 16'h0000;
  localparam logic [15:0] IOTFRC_COUNT_MAX   = 16'hffff;
  localparam logic [1:0] IOTFRC_RESP_OKAY   = 2'b00;
  localparam logic [1:0] IOTFRC_RESP_SLVERR = 2'b10;

  // Software-visible control bits carried together
  typedef struct packed {
    logic       irq_en;
    logic       stop;
    logic       clr_mode;
    logic [2:0] rate_sel;
  } iotfrc_ctrl_s;

endpackage : iotfrc_pkg

//--- verilog/iotfrc_timer.sv
// Free-running 16-bit timer with AXI4-Lite registers and its two compare channels
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns

module iotfrc_timer
  import iotfrc_pkg::*;
(
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [IOTFRC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [IOTFRC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic                     rmw_read,
  input  wire logic [1:0]               capture_pin,
  output logic [15:0]                   time_base,
  output logic [1:0]                    compare_out,
  output logic [1:0]                    capture_irq,
  output logic [1:0]                    capture_dma_req,
  output logic                          timer_irq
);

  // ==========================================================================
  // State
  logic [15:0]  count_q;
  iotfrc_ctrl_s ctrl_q;
  logic         irq_flag_q;
  logic         soft_zero_q;      // Pending software clear, served at next step
  logic [6:0]   prescale_q;
  logic         tick;
  logic [15:0]  cmp_q [2];
  logic [1:0]   cmp_out_q;
  logic [1:0]   cmp_flag_q;
  logic [1:0]   cmp_ien_q;
  logic [15:0]  cap_q [2];
  logic [1:0]   cap_flag_q;
  logic [3:0]   cap_edge_q;       // Per channel: {fall, rise}
  logic [1:0]   cap_s1_q;
  logic [1:0]   cap_s2_q;
  logic [1:0]   cap_s3_q;

  // Bus handshake state
  logic                     aw_held_q;
  logic                     w_held_q;
  logic [IOTFRC_ADDR_W-1:0] aw_addr_q;
  logic [31:0]              w_data_q;
  logic [3:0]               w_strb_q;

  // Divider mask for code n: the tick fires when the low n bits are all one
  function automatic logic rate_tick(input logic [6:0] pre, input logic [2:0] sel);
    logic [6:0] mask;
    mask = 7'((8'h01 << sel) - 8'h01);
    rate_tick = ((pre & mask) == mask);
  endfunction : rate_tick

  // Word address of a byte address (low two bits ignored)
  function automatic logic [IOTFRC_ADDR_W-1:0] word_of(input logic [IOTFRC_ADDR_W-1:0] a);
    word_of = {a[IOTFRC_ADDR_W-1:2], 2'b00};
  endfunction : word_of

  // ==========================================================================
  // Prescaler: running divider, code changes take effect at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescale_q <= 7'h00;
    end else begin
      prescale_q <= prescale_q + 7'h01;
    end
  end

  assign tick = rate_tick(prescale_q, ctrl_q.rate_sel);

  // ==========================================================================
  // Write channel capture: address and data accepted in either order
  logic wr_go;
  assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Ready only while the slot is empty, registered so outputs come from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_held_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // Decode of the held write
  logic       wr_count;
  logic       wr_ctrl;
  logic [1:0] wr_cmp;
  logic       wr_known;
  logic       wr_full16;
  always_comb begin
    wr_full16 = (w_strb_q[1:0] == 2'b11);
    wr_count  = wr_go && word_of(aw_addr_q) == IOTFRC_OFF_COUNT && wr_full16;
    wr_ctrl   = wr_go && word_of(aw_addr_q) == IOTFRC_OFF_CTRL && w_strb_q[0];
    wr_cmp[0] = wr_go && word_of(aw_addr_q) == IOTFRC_OFF_CMP0 && wr_full16;
    wr_cmp[1] = wr_go && word_of(aw_addr_q) == IOTFRC_OFF_CMP1 && wr_full16;
    wr_known  = word_of(aw_addr_q) == IOTFRC_OFF_COUNT || word_of(aw_addr_q) == IOTFRC_OFF_CTRL
             || word_of(aw_addr_q) == IOTFRC_OFF_CMP0 || word_of(aw_addr_q) == IOTFRC_OFF_CMP1;
  end

  // Write response: SLVERR for unmapped or a half-width count or compare access
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= IOTFRC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_known && (wr_full16 || word_of(aw_addr_q) == IOTFRC_OFF_CTRL))
                      ? IOTFRC_RESP_OKAY : IOTFRC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= iotfrc_ctrl_s'(6'(IOTFRC_CTRL_RESET));
    end else if (wr_ctrl) begin
      ctrl_q.irq_en   <= w_data_q[IOTFRC_B_IRQ_EN];
      ctrl_q.stop     <= w_data_q[IOTFRC_B_STOP];
      ctrl_q.clr_mode <= w_data_q[IOTFRC_B_CLR_MODE];
      ctrl_q.rate_sel <= w_data_q[IOTFRC_B_RATE_HI:0];
    end
  end

  // ==========================================================================
  // Counter: match and soft clear wait for the count step; reset is immediate
  logic [1:0] match;
  logic       ovf_step;
  logic       match_clr;
  always_comb begin
    match[0]  = (count_q == cmp_q[0]);
    match[1]  = (count_q == cmp_q[1]);
    ovf_step  = tick && !ctrl_q.stop && count_q == IOTFRC_COUNT_MAX;
    match_clr = tick && !ctrl_q.stop && ctrl_q.clr_mode && match[0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= IOTFRC_COUNT_RESET;
    end else if (wr_count) begin
      count_q <= w_data_q[15:0];
    end else if (tick && !ctrl_q.stop) begin
      if (soft_zero_q || match_clr) begin
        count_q <= IOTFRC_COUNT_RESET;
      end else begin
        count_q <= count_q + 16'h0001;
      end
    end
  end

  // Soft clear request waits for the next running count step
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_zero_q <= 1'b0;
    end else if (wr_ctrl && w_data_q[IOTFRC_B_SOFT_ZERO] && !w_data_q[IOTFRC_B_STOP]) begin
      soft_zero_q <= 1'b1;
    end else if ((tick && !ctrl_q.stop) || wr_count) begin
      soft_zero_q <= 1'b0;
    end
  end

  // Timer flag: hardware set wins over a software clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_flag_q <= 1'b0;
    end else if (ovf_step || match_clr) begin
      irq_flag_q <= 1'b1;
    end else if (wr_ctrl && !w_data_q[IOTFRC_B_IRQ_FLAG]) begin
      irq_flag_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Compare channels: value, start level, toggle on a counting step match
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_q[0]   <= IOTFRC_COUNT_MAX;
      cmp_q[1]   <= IOTFRC_COUNT_MAX;
      cmp_out_q  <= 2'b00;
      cmp_flag_q <= 2'b00;
      cmp_ien_q  <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_cmp[i]) begin
          cmp_q[i]     <= w_data_q[15:0];
          cmp_ien_q[i] <= w_data_q[16];
        end
        if (tick && !ctrl_q.stop && match[i]) begin
          cmp_out_q[i]  <= !cmp_out_q[i];
          cmp_flag_q[i] <= 1'b1;
        end else if (wr_cmp[i]) begin
          if (w_data_q[18]) begin
            cmp_out_q[i] <= w_data_q[17];
          end
          if (!w_data_q[19]) begin
            cmp_flag_q[i] <= 1'b0;
          end
        end
      end
    end
  end

  // ==========================================================================
  // Capture channels: pins synchronised, then edge detected on the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_s1_q <= 2'b00;
      cap_s2_q <= 2'b00;
      cap_s3_q <= 2'b00;
    end else begin
      cap_s1_q <= capture_pin;
      cap_s2_q <= cap_s1_q;
      cap_s3_q <= cap_s2_q;
    end
  end

  // Edge selects live in the control word bits 11:8, flags cleared by bits 13:12 = 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_edge_q <= 4'h0;
      cap_flag_q <= 2'b00;
      cap_q[0]   <= IOTFRC_COUNT_RESET;
      cap_q[1]   <= IOTFRC_COUNT_RESET;
    end else begin
      if (wr_ctrl && w_strb_q[1]) begin
        cap_edge_q <= w_data_q[11:8];
      end
      for (int i = 0; i < 2; i++) begin
        if ((cap_edge_q[2*i]   && cap_s2_q[i] && !cap_s3_q[i]) ||
            (cap_edge_q[2*i+1] && !cap_s2_q[i] && cap_s3_q[i])) begin
          cap_q[i]      <= count_q;
          cap_flag_q[i] <= 1'b1;
        end else if (wr_ctrl && w_strb_q[1] && !w_data_q[12+i]) begin
          cap_flag_q[i] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // Read channel: one cycle from address to data; spare upper bits carry capture values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= IOTFRC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= IOTFRC_RESP_OKAY;
      unique case (word_of(s_axi_araddr))
        IOTFRC_OFF_COUNT: s_axi_rdata <= {cap_q[0], count_q};
        IOTFRC_OFF_CTRL:  s_axi_rdata <= {2'b00, cap_q[1], cap_flag_q, cap_edge_q,
                                           irq_flag_q | rmw_read,
                                           ctrl_q.irq_en, ctrl_q.stop, ctrl_q.clr_mode,
                                           1'b0,
                                           ctrl_q.rate_sel};
        IOTFRC_OFF_CMP0:  s_axi_rdata <= {14'h0000, cmp_flag_q[0], cmp_ien_q[0], cmp_q[0]};
        IOTFRC_OFF_CMP1:  s_axi_rdata <= {14'h0000, cmp_flag_q[1], cmp_ien_q[1], cmp_q[1]};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= IOTFRC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================================
  // Registered outputs: time base, compare levels, interrupts, DMA triggers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      time_base       <= IOTFRC_COUNT_RESET;
      compare_out     <= 2'b00;
      capture_irq     <= 2'b00;
      capture_dma_req <= 2'b00;
      timer_irq       <= 1'b0;
    end else begin
      time_base       <= count_q;
      compare_out     <= cmp_out_q;
      capture_irq     <= cap_flag_q;
      capture_dma_req <= cap_flag_q;
      timer_irq       <= (irq_flag_q && ctrl_q.irq_en) ||
                         |(cmp_flag_q & cmp_ien_q);
    end
  end

endmodule : iotfrc_timer
